// ===== logic/bsc_pkg.sv
package bsc_pkg;
    // chain and instruction geometry
    localparam int BS_LEN = 45;
    localparam int IR_LEN = 5;
    localparam int ID_LEN = 32;
    localparam int TRST_TMS_TCKS = 5;
    // instruction codes
    localparam logic [4:0] IR_EXTEST = 5'h00;
    localparam logic [4:0] IR_IDCODE = 5'h01;
    localparam logic [4:0] IR_SAMPLE = 5'h02;
    localparam logic [4:0] IR_BYPASS = 5'h1F;
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    // load positions of the serial/output cells
    localparam int POS_BIDIR_OE = 0;
    localparam int POS_SER_OUT_EN = 1;
    localparam int POS_SER_OUT = 2;
    localparam int POS_PLL = 3;
    localparam int POS_IRQ = 4;
    localparam int POS_SDIO = 5;
    localparam int POS_SCLK = 6;
    localparam int POS_CS = 7;
    localparam int POS_RST = 8;
    localparam int UPD_LEN = 9;
    // data and clock/frame positions
    localparam int POS_B_MSB = 9;
    localparam int POS_A_MSB = 25;
    localparam int POS_FRAME_B = 41;
    localparam int POS_DCI_B = 42;
    localparam int POS_FRAME_A = 43;
    localparam int POS_DCI_A = 44;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } bsc_tap_t;

    typedef struct packed {
        logic [15:0] port_a;
        logic [15:0] port_b;
        logic port_a_data_clock_in;
        logic port_b_data_clock_in;
        logic port_a_frame_in;
        logic port_b_frame_in;
        logic reset_in;
        logic serial_chip_select_n;
        logic serial_clock_in;
        logic serial_data_in;
    } bsc_pin_in_t;

    typedef struct packed {
        logic extest;
        logic serial_bidir_output_enable;
        logic serial_bidir_data;
        logic serial_out_enable;
        logic serial_data_out_pin;
        logic pll_lock;
        logic irq;
    } bsc_pin_out_t;

    typedef struct packed {
        bsc_tap_t tap;
        logic [IR_LEN-1:0] ir;
        logic [IR_LEN-1:0] ir_sh;
        logic [BS_LEN-1:0] sh;
        logic [UPD_LEN-1:0] upd;
        logic sdio_pre;
        logic tck_d;
        logic tdo;
        logic tdo_oe;
        bsc_pin_out_t po;
    } bsc_state_t;
endpackage

// ===== logic/bsc_sync.sv
`timescale 1ns/1ps
module bsc_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    if (W < 1) begin : g_bad_w
        $error("bsc_sync width must be positive");
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // bsc_sync

// ===== logic/bsc_chain.sv
`timescale 1ns/1ps
module bsc_chain import bsc_pkg::*; #(
    parameter logic [31:0] ID_CODE = 32'h1000_0001 // arbitrary value
) (
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // device pins
    input wire bsc_pin_in_t pins_in,
    output bsc_pin_out_t pins_out
);
    if (ID_CODE[0] != 1'b1) begin : g_bad_id
        $error("identification code must end in a one");
    end

    bsc_state_t s_r;
    bsc_state_t s_nxt;
    logic [2:0] tp_s;
    bsc_pin_in_t pin_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic rise;
    logic fall;
    logic sel_bs;
    logic sel_id;

    bsc_sync #(.W(3)) u_tap_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({tck, tms, tdi}),
        .q(tp_s)
    );

    bsc_sync #(.W($bits(bsc_pin_in_t))) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(pins_in),
        .q(pin_s)
    );

    assign tck_s = tp_s[2];
    assign tms_s = tp_s[1];
    assign tdi_s = tp_s[0];
    // tck is slow against clk, so edges are found on the synced copy
    assign rise = tck_s & ~s_r.tck_d;
    assign fall = ~tck_s & s_r.tck_d;
    assign sel_bs = (s_r.ir == IR_EXTEST) || (s_r.ir == IR_SAMPLE);
    assign sel_id = (s_r.ir == IR_IDCODE);

    function automatic bsc_tap_t tap_next(bsc_tap_t t, logic m);
        case (t)
            TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction

    always_comb begin
        logic [BS_LEN-1:0] cap;
        cap = '0;
        // unload view: enable cell of the bidir pin is skipped
        cap[0] = s_r.upd[POS_SER_OUT_EN];
        cap[1] = s_r.upd[POS_SER_OUT];
        cap[2] = s_r.upd[POS_PLL];
        cap[3] = s_r.upd[POS_IRQ];
        cap[4] = s_r.sdio_pre;
        // live pins resampled at readback
        cap[5] = pin_s.serial_data_in;
        cap[6] = pin_s.serial_clock_in;
        cap[7] = pin_s.serial_chip_select_n;
        cap[8] = pin_s.reset_in;
        // loaded serial out, pll and irq cells also echo two cells lower
        for (int k = POS_SER_OUT; k <= POS_IRQ; k++) begin
            cap[k] = cap[k] | s_r.upd[k];
            cap[k-2] = cap[k-2] | s_r.upd[k];
        end
        for (int i = 0; i < 16; i++) begin
            cap[POS_B_MSB+i] = pin_s.port_b[15-i];
            cap[POS_A_MSB+i] = pin_s.port_a[15-i];
        end
        // port A clock/frame fan out to both pairs of cells
        cap[POS_FRAME_B] = pin_s.port_b_frame_in | pin_s.port_a_frame_in;
        cap[POS_DCI_B] = pin_s.port_b_data_clock_in | pin_s.port_a_data_clock_in;
        cap[POS_FRAME_A] = pin_s.port_a_frame_in;
        cap[POS_DCI_A] = pin_s.port_a_data_clock_in;

        s_nxt = s_r;
        s_nxt.tck_d = tck_s;
        if (rise) begin
            s_nxt.tap = tap_next(s_r.tap, tms_s);
            case (s_r.tap)
                TAP_CAP_DR: begin
                    if (sel_bs) begin
                        s_nxt.sh = cap;
                    end else if (sel_id) begin
                        s_nxt.sh = {13'h0000, ID_CODE};
                    end else begin
                        s_nxt.sh = '0;
                    end
                    if (s_r.ir == IR_SAMPLE) begin
                        s_nxt.sdio_pre = pin_s.serial_data_in;
                    end
                end
                TAP_SH_DR: begin
                    // lsb leaves first, tdi enters at the selected length
                    if (sel_bs) begin
                        s_nxt.sh = {tdi_s, s_r.sh[BS_LEN-1:1]};
                    end else if (sel_id) begin
                        s_nxt.sh = {13'h0000, tdi_s, s_r.sh[ID_LEN-1:1]};
                    end else begin
                        s_nxt.sh = {44'h0000_0000_000, tdi_s};
                    end
                end
                TAP_CAP_IR: s_nxt.ir_sh = IR_CAPTURE;
                TAP_SH_IR: s_nxt.ir_sh = {tdi_s, s_r.ir_sh[IR_LEN-1:1]};
                default: s_nxt.ir_sh = s_r.ir_sh;
            endcase
        end
        if (fall) begin
            s_nxt.tdo_oe = (s_r.tap == TAP_SH_DR) || (s_r.tap == TAP_SH_IR);
            s_nxt.tdo = (s_r.tap == TAP_SH_IR) ? s_r.ir_sh[0] : s_r.sh[0];
            if (s_r.tap == TAP_UPD_IR) begin
                s_nxt.ir = s_r.ir_sh;
            end
            // load cells in load order
            if (s_r.tap == TAP_UPD_DR && sel_bs) begin
                s_nxt.upd = s_r.sh[UPD_LEN-1:0];
            end
        end
        if (s_r.tap == TAP_TLR) begin
            s_nxt.ir = IR_IDCODE;
        end
        // pins only driven under extest; nothing reaches the core
        s_nxt.po.extest = (s_nxt.ir == IR_EXTEST);
        s_nxt.po.serial_bidir_output_enable = s_nxt.po.extest & s_nxt.upd[POS_BIDIR_OE];
        s_nxt.po.serial_bidir_data = s_nxt.po.extest & s_nxt.upd[POS_SDIO];
        s_nxt.po.serial_out_enable = s_nxt.po.extest & s_nxt.upd[POS_SER_OUT_EN];
        s_nxt.po.serial_data_out_pin = s_nxt.po.extest & s_nxt.upd[POS_SER_OUT];
        s_nxt.po.pll_lock = s_nxt.po.extest & s_nxt.upd[POS_PLL];
        s_nxt.po.irq = s_nxt.po.extest & s_nxt.upd[POS_IRQ];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.tap <= TAP_TLR;
            s_r.ir <= IR_IDCODE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tdo = s_r.tdo;
    assign tdo_oe = s_r.tdo_oe;
    assign pins_out = s_r.po;

    // helper: tck rises seen with tms high in a row
    logic [2:0] tms_hi_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            tms_hi_r <= 3'h0;
        end else if (ce && rise) begin
            tms_hi_r <= !tms_s ? 3'h0 : (tms_hi_r == 3'h7 ? 3'h7 : tms_hi_r + 3'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tms_reset: assert property (tms_hi_r >= TRST_TMS_TCKS |-> s_r.tap == TAP_TLR)
        else $error("controller not reset after five tms high clocks");
    a_ir_power_on: assert property ($fell(rst) |-> s_r.ir == IR_IDCODE
        && s_r.tap == TAP_TLR)
        else $error("instruction not idcode after reset");
    a_dci_a_dual: assert property (ce && rise && s_r.tap == TAP_CAP_DR && sel_bs
        |=> s_r.sh[POS_DCI_B] == ($past(pin_s.port_a_data_clock_in)
        | $past(pin_s.port_b_data_clock_in))
        && s_r.sh[POS_DCI_A] == $past(pin_s.port_a_data_clock_in))
        else $error("data clock cells wrong at capture");
    a_frame_b_single: assert property (ce && rise && s_r.tap == TAP_CAP_DR && sel_bs
        && !pin_s.port_a_frame_in |=> s_r.sh[POS_FRAME_B] == $past(pin_s.port_b_frame_in)
        && !s_r.sh[POS_FRAME_A])
        else $error("port b frame not alone at its cell");
    // a loaded serial output echoes into cell 0, so only the enable alone is judged
    a_oe_hidden: assert property (ce && rise && s_r.tap == TAP_CAP_DR && sel_bs
        && s_r.upd[POS_SER_OUT_EN:POS_BIDIR_OE] == 2'h1 && !s_r.upd[POS_SER_OUT]
        |=> s_r.sh[0] == 1'b0)
        else $error("bidir enable cell seen in unload");
    a_irq_echo: assert property (ce && rise && s_r.tap == TAP_CAP_DR && sel_bs
        && s_r.upd[POS_IRQ] |=> s_r.sh[POS_IRQ] && s_r.sh[POS_IRQ-2])
        else $error("loaded irq not echoed at two cells");
    a_data_order: assert property (ce && rise && s_r.tap == TAP_CAP_DR && sel_bs
        |=> s_r.sh[POS_B_MSB] == $past(pin_s.port_b[15])
        && s_r.sh[40] == $past(pin_s.port_a[0]))
        else $error("data bits in wrong chain order");
    a_bypass_zero: assert property (ce && rise && s_r.tap == TAP_CAP_DR && !sel_bs
        && !sel_id |=> s_r.sh == '0)
        else $error("bypass capture not zero");
    a_pins_quiet: assert property (!pins_out.extest |-> pins_out[5:0] == 6'h00)
        else $error("pins driven outside extest");
    a_tdo_lsb: assert property (ce && fall && s_r.tap == TAP_SH_DR
        |=> tdo == $past(s_r.sh[0]) && tdo_oe)
        else $error("tdo not the chain lsb");

    c_extest_load: cover property (ce && fall && s_r.tap == TAP_UPD_DR && s_r.ir == IR_EXTEST);
    c_id_shift: cover property (ce && rise && s_r.tap == TAP_SH_DR && sel_id);
    c_tms_reset: cover property (tms_hi_r == 3'h5);
endmodule // bsc_chain

// ===== tb/bsc_tester.sv
`timescale 1ns/1ps
module bsc_tester (
    // system
    input wire logic clk,
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one test clock; tdo taken late in the low phase, after the device settled it
    task automatic pulse(input logic m, input logic d, output logic q);
        @(posedge clk) #1;
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (20) @(posedge clk);
        q = tdo;
        #1;
        tck = 1'b1;
        repeat (19) @(posedge clk);
    endtask
    // capture, shift lsb first, update, back to idle
    task automatic scan(input logic ir_sel, input int n, input logic [63:0] din,
        output logic [63:0] dout);
        logic q;
        dout = '0;
        pulse(1'b0, 1'b0, q);
        pulse(1'b1, 1'b0, q);
        if (ir_sel)
            pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) pulse(1'b1, 1'b0, q);
    endtask
endmodule // bsc_tester

// ===== tb/boundary_scan_chain_bench.sv
`timescale 1ns/1ps
module boundary_scan_chain_bench;
    import bsc_pkg::*;
    localparam logic [31:0] ID = 32'h1000_0001; // arbitrary value
    logic clk, rst, ce, tck, tms, tdi, tdo, tdo_oe;
    bsc_pin_in_t pins_in;
    bsc_pin_out_t pins_out;
    int error_cnt = 0;
    int check_count = 0;
    logic [63:0] rd;
    logic [44:0] samp;

    bsc_chain #(.ID_CODE(ID)) u_bsc_chain (.clk(clk), .rst(rst), .ce(ce), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pins_in(pins_in),
        .pins_out(pins_out));
    bsc_tester u_bsc_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({63'h0, got}, {63'h0, exp});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic test_idcode();
        u_bsc_tester.scan(1'b0, 32, 64'h0, rd);
        chk_vec(rd, {32'h0, ID});
        chk_bit(tdo_oe, 1'b0);
        $display("test idcode done");
    endtask
    task automatic test_bypass();
        logic [4:0] codes [2] = '{IR_BYPASS, 5'h0A};
        foreach (codes[k]) begin
            u_bsc_tester.scan(1'b1, 5, {59'h0, codes[k]}, rd);
            chk_vec(rd, 64'h1);
            u_bsc_tester.scan(1'b0, 8, 64'hB5, rd);
            chk_vec(rd, 64'h6A);
        end
        $display("test bypass done");
    endtask
    task automatic test_sample();
        samp = '0;
        samp[8:4] = {pins_in.reset_in, pins_in.serial_chip_select_n,
            pins_in.serial_clock_in, pins_in.serial_data_in, pins_in.serial_data_in};
        for (int i = 0; i < 16; i++) begin
            samp[9 + i] = pins_in.port_b[15 - i];
            samp[25 + i] = pins_in.port_a[15 - i];
        end
        // a clock high sets 42 and 44, b frame only 41
        samp[44:41] = 4'hB;
        u_bsc_tester.scan(1'b1, 5, {59'h0, IR_SAMPLE}, rd);
        u_bsc_tester.scan(1'b0, 45, 64'h0, rd);
        u_bsc_tester.scan(1'b0, 45, 64'h0, rd);
        chk_vec(rd, {19'h0, samp});
        chk_bit(pins_out.extest, 1'b0);
        // swapped pairs: b clock alone at 42, a frame at 41 and 43
        @(posedge clk) #1;
        pins_in.port_a_data_clock_in = 1'b0;
        pins_in.port_b_data_clock_in = 1'b1;
        pins_in.port_a_frame_in = 1'b1;
        pins_in.port_b_frame_in = 1'b0;
        samp[44:41] = 4'h7;
        u_bsc_tester.scan(1'b0, 45, 64'h0, rd);
        chk_vec(rd, {19'h0, samp});
        $display("test sample done");
    endtask
    task automatic test_extest();
        // serial data moves after the preload: readback shows both values
        @(posedge clk) #1;
        pins_in.serial_data_in = 1'b0;
        u_bsc_tester.scan(1'b1, 5, {59'h0, IR_EXTEST}, rd);
        chk_bit(pins_out.extest, 1'b1);
        u_bsc_tester.scan(1'b0, 45, 64'h9, rd);
        chk_bit(pins_out.pll_lock, 1'b1);
        chk_bit(pins_out.serial_bidir_output_enable, 1'b1);
        chk_bit(pins_out.irq, 1'b0);
        // second load drives the remaining outputs and reads the first back
        u_bsc_tester.scan(1'b0, 45, 64'h36, rd);
        chk_vec(rd, {19'h0, (samp & ~45'h20) | 45'hE});
        chk_bit(rd[4], 1'b1);
        chk_bit(rd[5], 1'b0);
        chk_bit(pins_out.serial_out_enable, 1'b1);
        chk_bit(pins_out.serial_data_out_pin, 1'b1);
        chk_bit(pins_out.irq, 1'b1);
        chk_bit(pins_out.serial_bidir_data, 1'b1);
        chk_bit(pins_out.pll_lock, 1'b0);
        chk_bit(pins_out.serial_bidir_output_enable, 1'b0);
        // irq and serial out each echo two cells lower
        u_bsc_tester.scan(1'b0, 45, 64'h0, rd);
        chk_vec(rd, {19'h0, (samp & ~45'h20) | 45'hF});
        $display("test extest done");
    endtask
    task automatic test_reset();
        // a frozen block ignores the tester, so the instruction survives
        @(posedge clk) #1;
        ce = 1'b0;
        u_bsc_tester.reset_tap();
        @(posedge clk) #1;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        chk_bit(pins_out.extest, 1'b1);
        u_bsc_tester.reset_tap();
        chk_bit(pins_out.extest, 1'b0);
        test_idcode();
        $display("test reset done");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        pins_in = '0;
        pins_in.port_a = 16'hA5C3;
        pins_in.port_b = 16'h1E69;
        pins_in.port_a_data_clock_in = 1'b1;
        pins_in.port_b_frame_in = 1'b1;
        pins_in.serial_chip_select_n = 1'b1;
        pins_in.serial_data_in = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        test_idcode();
        test_bypass();
        test_sample();
        test_extest();
        test_reset();
        end_of_test();
    end
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule // boundary_scan_chain_bench
